// ---- rtl/kwu_key_wakeup.sv ----
`timescale 1ns/1ps
// What this block does
// - after reset only the stop-release pin wakes; all key enables cleared
// - a key input wakes only when its own enable bit is one
// - level bit zero wakes on low input, one wakes on high input
// - the stop-release pin has no disable and always can wake
// - two 8-bit registers, four pins each, level above enable, high pin top
// - in level mode leave stop on stop pin high or enabled key at its level; in edge mode (the reset setting) only on stop pin rise
// - request refused with no warm-up when a wake level already stands
module kwu_key_wakeup #(
  parameter int unsigned NUM_KEYS = kwu_pkg::KWU_NUM_KEYS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_release_pin,
  input wire logic [NUM_KEYS-1:0] key_wake_input,
  output logic stop_mode,
  output logic irq
);
  logic [7:0] key_wake_ctrl_low_pins_q;
  logic [7:0] key_wake_ctrl_high_pins_q;
  logic [7:0] system_control_one_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [31:0] prdata_q;
  logic [NUM_KEYS:0] pins_level;
  logic stop_level;
  logic stop_level_prev_q;
  logic stop_rise;
  logic [NUM_KEYS-1:0] key_input_wake_enable;
  logic [NUM_KEYS-1:0] key_input_release_level;
  logic [NUM_KEYS-1:0] key_hit;
  logic wake_req;
  logic release_now;
  logic refuse_now;
  logic enter_now;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic [11:0] idx;
  kwu_pkg::kwu_state_e state_q;

  // pick every other bit of the two control registers
  function automatic logic [7:0] kwu_pick(input logic [15:0] ctrl,
                                          input logic odd);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = ctrl[2*i + (odd ? 1 : 0)];
    end
    return r;
  endfunction

  // one when the index names one of the six registers, else zero
  function automatic logic is_reg(input logic [11:0] i);
    return (i == kwu_pkg::KWU_IDX_CTRL_LOW) ||
           (i == kwu_pkg::KWU_IDX_CTRL_HIGH) ||
           (i == kwu_pkg::KWU_IDX_STATUS) ||
           (i == kwu_pkg::KWU_IDX_MASK) ||
           (i == kwu_pkg::KWU_IDX_PINS) ||
           (i == kwu_pkg::KWU_IDX_SYSCTL);
  endfunction

  kwu_pin_sync #(
    .WIDTH(NUM_KEYS + 1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({stop_release_pin, key_wake_input}),
    .level_q(pins_level)
  );

  assign stop_level = pins_level[NUM_KEYS];

  // apb decode, zero wait state
  assign idx = paddr[13:2];
  assign addr_ok = (paddr[31:14] == '0) && (paddr[1:0] == 2'h0) &&
                   is_reg(idx);
  assign wr_acc = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;

  // per pin enable and level, level bit sits above enable
  assign key_input_wake_enable = NUM_KEYS'(kwu_pick(
    {key_wake_ctrl_high_pins_q, key_wake_ctrl_low_pins_q}, 1'b0));
  assign key_input_release_level = NUM_KEYS'(kwu_pick(
    {key_wake_ctrl_high_pins_q, key_wake_ctrl_low_pins_q}, 1'b1));

  // enabled key matching its programmed level
  assign key_hit = key_input_wake_enable &
    ~(pins_level[NUM_KEYS-1:0] ^ key_input_release_level);
  assign wake_req = stop_level || (|key_hit);

  // level mode wakes on any request, edge mode on stop pin rise
  assign stop_rise = stop_level && !stop_level_prev_q;
  assign release_now = (state_q == kwu_pkg::KWU_STOP) &&
    (system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] ?
     wake_req : stop_rise);
  assign refuse_now = (state_q == kwu_pkg::KWU_RUN) &&
    system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] && wake_req;
  assign enter_now = (state_q == kwu_pkg::KWU_RUN) &&
    system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] && !wake_req;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_level_prev_q <= 1'b0;
    end
    else
    begin
      stop_level_prev_q <= stop_level;
    end
  end

  // key control registers, cleared by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_wake_ctrl_low_pins_q <= kwu_pkg::KWU_RST_CTRL;
      key_wake_ctrl_high_pins_q <= kwu_pkg::KWU_RST_CTRL;
    end
    else if (wr_acc)
    begin
      if (idx == kwu_pkg::KWU_IDX_CTRL_LOW)
      begin
        key_wake_ctrl_low_pins_q <= pwdata[7:0];
      end
      if (idx == kwu_pkg::KWU_IDX_CTRL_HIGH)
      begin
        key_wake_ctrl_high_pins_q <= pwdata[7:0];
      end
    end
  end

  // system control, stop request cleared by hardware on exit or refusal
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      system_control_one_q <= kwu_pkg::KWU_RST_SYSCTL;
    end
    else
    begin
      if (wr_acc && idx == kwu_pkg::KWU_IDX_SYSCTL)
      begin
        system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] <=
          pwdata[kwu_pkg::KWU_SYS_STOP_BIT];
        system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] <=
          pwdata[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT];
      end
      if (refuse_now || release_now)
      begin
        system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] <= 1'b0;
      end
    end
  end

  // run and stop sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= kwu_pkg::KWU_RUN;
    end
    else
    begin
      unique case (state_q)
        kwu_pkg::KWU_RUN:
        begin
          if (enter_now)
          begin
            state_q <= kwu_pkg::KWU_STOP;
          end
        end
        kwu_pkg::KWU_STOP:
        begin
          if (release_now)
          begin
            state_q <= kwu_pkg::KWU_RUN;
          end
        end
      endcase
    end
  end

  assign stop_mode = (state_q == kwu_pkg::KWU_STOP);

  // sticky status, set wins over write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= kwu_pkg::KWU_RST_STATUS;
    end
    else
    begin
      if (wr_acc && idx == kwu_pkg::KWU_IDX_STATUS)
      begin
        status_q <= status_q & ~pwdata[1:0];
      end
      if (release_now)
      begin
        status_q[kwu_pkg::KWU_ST_WOKE_BIT] <= 1'b1;
      end
      if (refuse_now)
      begin
        status_q[kwu_pkg::KWU_ST_REFUSED_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q <= kwu_pkg::KWU_RST_MASK;
    end
    else if (wr_acc && idx == kwu_pkg::KWU_IDX_MASK)
    begin
      mask_q <= pwdata[1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else if (rd_setup)
    begin
      prdata_q <= '0;
      if (addr_ok)
      begin
        unique case (idx)
          kwu_pkg::KWU_IDX_CTRL_LOW:
            prdata_q[7:0] <= key_wake_ctrl_low_pins_q;
          kwu_pkg::KWU_IDX_CTRL_HIGH:
            prdata_q[7:0] <= key_wake_ctrl_high_pins_q;
          kwu_pkg::KWU_IDX_STATUS:
            prdata_q[1:0] <= status_q;
          kwu_pkg::KWU_IDX_MASK:
            prdata_q[1:0] <= mask_q;
          kwu_pkg::KWU_IDX_PINS:
            prdata_q[NUM_KEYS:0] <= pins_level;
          kwu_pkg::KWU_IDX_SYSCTL:
            prdata_q[7:0] <= system_control_one_q;
          default:
            prdata_q <= '0;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  no_key_disabled_a: assert property (
    (state_q == kwu_pkg::KWU_STOP) && !stop_level &&
    system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] &&
    (key_hit == '0) |=> stop_mode)
    else $error("stop left without an enabled key match");

  key_level_wake_a: assert property (
    stop_mode && system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] &&
    (|(key_input_wake_enable &
       ~(pins_level[NUM_KEYS-1:0] ^ key_input_release_level)))
    |=> !stop_mode)
    else $error("enabled key at its level did not wake");

  stop_pin_wake_a: assert property (
    stop_mode && system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] &&
    stop_level |=> !stop_mode && status_q[kwu_pkg::KWU_ST_WOKE_BIT])
    else $error("stop pin high did not wake");

  edge_wake_a: assert property (
    stop_mode && !system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] &&
    stop_level && !$past(stop_level) |=> !stop_mode)
    else $error("stop pin rise did not wake in edge mode");

  refuse_entry_a: assert property (
    !stop_mode && system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] &&
    wake_req |=> !stop_mode &&
    !system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] &&
    status_q[kwu_pkg::KWU_ST_REFUSED_BIT])
    else $error("stop entered although a wake level stood");

  stop_entry_a: assert property (
    !stop_mode && system_control_one_q[kwu_pkg::KWU_SYS_STOP_BIT] &&
    !wake_req |=> stop_mode)
    else $error("stop request not honoured");

  wake_or_form_a: assert property (
    wake_req == (stop_level ||
      (|(key_input_wake_enable &
         ~(pins_level[NUM_KEYS-1:0] ^ key_input_release_level)))))
    else $error("wake request not formed from pin and keys");

  ctrl_write_a: assert property (
    wr_acc && idx == kwu_pkg::KWU_IDX_CTRL_HIGH |=>
    key_input_wake_enable[4] == $past(pwdata[0]) &&
    key_input_release_level[NUM_KEYS-1] == $past(pwdata[7]))
    else $error("key control bit layout wrong");

  reset_enables_a: assert property (
    $rose(presetn) |-> key_input_wake_enable == '0)
    else $error("key enables not clear after reset");

  irq_level_a: assert property (
    refuse_now && mask_q[kwu_pkg::KWU_ST_REFUSED_BIT] &&
    !(wr_acc && idx == kwu_pkg::KWU_IDX_MASK) |=> irq)
    else $error("masked refusal did not raise the interrupt");

  enter_stop_c: cover property (!stop_mode ##1 stop_mode);
  key_wake_c: cover property (stop_mode && (|key_hit) ##1 !stop_mode);
  refuse_c: cover property (refuse_now);
  edge_wake_c: cover property (
    stop_mode && !system_control_one_q[kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT] &&
    stop_rise);
endmodule

// ---- rtl/kwu_pkg.sv ----
package kwu_pkg;
  localparam int unsigned KWU_NUM_KEYS = 8;
  // register indices, byte address is four times the index
  localparam logic [11:0] KWU_IDX_CTRL_LOW = 12'hFC4;
  localparam logic [11:0] KWU_IDX_CTRL_HIGH = 12'hFC5;
  localparam logic [11:0] KWU_IDX_STATUS = 12'hFC8;
  localparam logic [11:0] KWU_IDX_MASK = 12'hFC9;
  localparam logic [11:0] KWU_IDX_PINS = 12'hFCA;
  localparam logic [11:0] KWU_IDX_SYSCTL = 12'hFCB;
  // field positions
  localparam int unsigned KWU_SYS_STOP_BIT = 7;
  localparam int unsigned KWU_SYS_RELEASE_MODE_SELECT_BIT = 6;
  localparam int unsigned KWU_ST_WOKE_BIT = 0;
  localparam int unsigned KWU_ST_REFUSED_BIT = 1;
  localparam int unsigned KWU_PINS_STOP_BIT = 8;
  // values after reset
  localparam logic [7:0] KWU_RST_CTRL = 8'h00;
  localparam logic [7:0] KWU_RST_SYSCTL = 8'h00;
  localparam logic [1:0] KWU_RST_STATUS = 2'h0;
  localparam logic [1:0] KWU_RST_MASK = 2'h0;
  // pin synchroniser depth in flip-flops
  localparam int unsigned KWU_SYNC_STAGES = 3;
  typedef enum logic {KWU_RUN, KWU_STOP} kwu_state_e;
endpackage

// ---- rtl/kwu_pin_sync.sv ----
`timescale 1ns/1ps
module kwu_pin_sync #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // three stage chain, first stage only feeds the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q <= '0;
    end
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ---- testbench/kwu_key_model.sv ----
`timescale 1ns/1ps
// external switches on the wake pins, driven straight from bench commands
module kwu_key_model (
  input wire logic stop_cmd,
  input wire logic [7:0] key_cmd,
  input wire logic [7:0] key_float,
  input wire logic [7:0] pullup_en,
  output logic stop_release_pin,
  output logic [7:0] key_wake_input
);
  assign stop_release_pin = stop_cmd;
  // a floating key reads high only through an enabled pull-up
  assign key_wake_input = (key_cmd & ~key_float) |
    (pullup_en & key_float);
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, stop_cmd;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, stop_release_pin, stop_mode, irq;
  logic [7:0] key_cmd, key_wake_input, key_float, pullup_en;
  int failures = 0;
  int total_checks = 0;
  localparam logic [11:0] ilo = kwu_pkg::KWU_IDX_CTRL_LOW;
  localparam logic [11:0] ihi = kwu_pkg::KWU_IDX_CTRL_HIGH;
  localparam logic [11:0] ist = kwu_pkg::KWU_IDX_STATUS;
  localparam logic [11:0] imsk = kwu_pkg::KWU_IDX_MASK;
  localparam logic [11:0] isys = kwu_pkg::KWU_IDX_SYSCTL;
  localparam logic [31:0] go_stop = (32'h1 << kwu_pkg::KWU_SYS_STOP_BIT)
    | (32'h1 << kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT);
  localparam logic [31:0] refused = 32'h1 << kwu_pkg::KWU_ST_REFUSED_BIT;
  localparam logic [11:0] ipins = kwu_pkg::KWU_IDX_PINS;
  localparam logic [31:0] edge_stop = 32'h1 << kwu_pkg::KWU_SYS_STOP_BIT;
  localparam logic [31:0] woke = 32'h1 << kwu_pkg::KWU_ST_WOKE_BIT;
  localparam logic [31:0] pins_all =
    (32'h1 << kwu_pkg::KWU_PINS_STOP_BIT) | 32'hFF;
  kwu_key_wakeup kwu_key_wakeup_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .stop_release_pin(stop_release_pin), .key_wake_input(key_wake_input),
    .stop_mode(stop_mode), .irq(irq)
  );
  kwu_key_model kwu_key_model_i (
    .stop_cmd(stop_cmd), .key_cmd(key_cmd), .key_float(key_float),
    .pullup_en(pullup_en),
    .stop_release_pin(stop_release_pin), .key_wake_input(key_wake_input)
  );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xfer(input logic [11:0] idx, input logic w,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {18'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(idx, 1'b1, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] idx,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(idx, 1'b0, 32'h0, r, e);
    check(what, exp, r);
  endtask
  task automatic wait_stop(input logic exp, input int lim);
    int n;
    n = 0;
    while (stop_mode !== exp && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    check("stop_mode", {31'h0, exp}, {31'h0, stop_mode});
  endtask
  task automatic chk_irq(input logic exp);
    idle(1);
    check("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd_chk("ctrl_low", ilo, {24'h0, kwu_pkg::KWU_RST_CTRL});
    rd_chk("ctrl_high", ihi, {24'h0, kwu_pkg::KWU_RST_CTRL});
    wr(ilo, 32'hFFFF_FF55);
    wr(ilo, 32'hFFFF_FFD5);
    wr(ihi, 32'h0000_0014);
    wr(ihi, 32'h0000_003C);
    rd_chk("ctrl_low", ilo, 32'h0000_00D5);
    rd_chk("ctrl_high", ihi, 32'h0000_003C);
    xfer(12'hFF0, 1'b0, 32'h0, r, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    check("unmapped_data", 32'h0, r);
    xfer(ilo, 1'b1, 32'h0, r, e);
    check("mapped_err", 32'h0, {31'h0, e});
    check("pready", 32'h1, {31'h0, pready});
    wr(ihi, 32'h0);
  endtask
  task automatic t_stop_pin;
    wr(isys, go_stop);
    wait_stop(1'b1, 10);
    key_cmd <= 8'hFF;
    idle(8);
    check("stop_mode", 32'h1, {31'h0, stop_mode});
    stop_cmd <= 1'b1;
    wait_stop(1'b0, 12);
    rd_chk("status", ist, woke);
    rd_chk("pins", ipins, pins_all);
    stop_cmd <= 1'b0;
    wr(ist, 32'h3);
    idle(4);
    wr(isys, edge_stop);
    wait_stop(1'b1, 10);
    stop_cmd <= 1'b1;
    wait_stop(1'b0, 12);
    rd_chk("edge_status", ist, woke);
    stop_cmd <= 1'b0;
    wr(ist, 32'h3);
  endtask
  task automatic t_keys;
    logic [11:0] idx;
    logic [31:0] v;
    int b;
    for (int k = 0; k < 8; k++)
      for (int lev = 0; lev < 2; lev++)
      begin
        idx = (k < 4) ? ilo : ihi;
        b = 2 * (k % 4);
        v = (32'h1 << b) | (32'(lev) << (b + 1));
        key_cmd <= (lev == 1) ? 8'h00 : 8'hFF;
        wr(idx, 32'h1 << b);
        wr(idx, v);
        rd_chk("ctrl", idx, v);
        wr(isys, go_stop);
        wait_stop(1'b1, 10);
        key_cmd <= key_cmd ^ ~(8'h1 << k);
        idle(8);
        check("stop_mode", 32'h1, {31'h0, stop_mode});
        key_cmd[k] <= lev[0];
        wait_stop(1'b0, 12);
        wr(idx, 32'h0);
      end
  endtask
  task automatic t_refuse;
    wr(ist, 32'h3);
    wr(imsk, refused);
    key_cmd <= 8'h00;
    pullup_en <= 8'h01;
    key_float <= 8'h01;
    wr(ilo, 32'h1);
    wr(ilo, 32'h3);
    wr(isys, go_stop);
    idle(4);
    check("stop_mode", 32'h0, {31'h0, stop_mode});
    rd_chk("sysctl", isys, 32'h1 << kwu_pkg::KWU_SYS_RELEASE_MODE_SELECT_BIT);
    rd_chk("status", ist, refused);
    chk_irq(1'b1);
    wr(imsk, 32'h0);
    chk_irq(1'b0);
    wr(imsk, refused);
    chk_irq(1'b1);
    wr(ist, refused);
    chk_irq(1'b0);
    wr(ilo, 32'h0);
    key_float <= 8'h00;
    stop_cmd <= 1'b1;
    idle(6);
    wr(isys, go_stop);
    idle(4);
    check("stop_mode", 32'h0, {31'h0, stop_mode});
    rd_chk("status", ist, refused);
    stop_cmd <= 1'b0;
  endtask
  task automatic t_mid_reset;
    wr(ihi, 32'h3);
    key_cmd <= 8'h00;
    idle(6);
    wr(isys, go_stop);
    wait_stop(1'b1, 10);
    presetn <= 1'b0;
    idle(2);
    check("stop_mode", 32'h0, {31'h0, stop_mode});
    presetn <= 1'b1;
    rd_chk("ctrl_high", ihi, 32'h0);
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    stop_cmd = 1'b0;
    key_cmd = 8'h00;
    key_float = 8'h00;
    pullup_en = 8'h00;
    idle(2);
    presetn <= 1'b1;
    t_regs();
    t_stop_pin();
    t_keys();
    t_refuse();
    t_mid_reset();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
